//--- design/dic_defs.vh
// Constants for the DSP interrupt controller
`ifndef DIC_DEFS_VH
`define DIC_DEFS_VH

// Register indices on the plain register port
`define DIC_ADDR_CONTROL   4'h0
`define DIC_ADDR_MASK      4'h1
`define DIC_ADDR_LATCH     4'h2
`define DIC_ADDR_PRIO0     4'h3
`define DIC_ADDR_PRIO1     4'h4
`define DIC_ADDR_PRIO2     4'h5
`define DIC_ADDR_PRIO3     4'h6
`define DIC_ADDR_FLAGCFG   4'h7
`define DIC_ADDR_STATUS    4'h8
`define DIC_ADDR_CMD       4'h9

// Control register fields
`define DIC_CTL_NEST       4
`define DIC_CTL_GIE        5
`define DIC_CTL_BIAS       7
`define DIC_CTL_PCSTK      10
`define DIC_CTL_LPSTK      11
`define DIC_CTL_WMASK      16'h0CB0

// Latch bit positions
`define DIC_BIT_RESET      0
`define DIC_BIT_PWRDN      1
`define DIC_BIT_STACK      2
`define DIC_BIT_KERNEL     3
`define DIC_BIT_USER0      4

// Vectors
`define DIC_VEC_BASE       24'h000000
`define DIC_VEC_NOBOOT     24'h010000
`define DIC_VEC_STEP       24'h000020

// Peripheral priority
`define DIC_NUM_PERIPH     15
`define DIC_LVL_LOWEST     4'hB
`define DIC_PRIO_RESET     60'hBBB_BA98_7654_3210

// Stack sizes and thresholds
`define DIC_PC_DEPTH       33
`define DIC_LOOP_DEPTH     8
`define DIC_STAT_DEPTH     16
`define DIC_PC_LOW         3
`define DIC_PC_HIGH        28

// Flag trigger modes
`define DIC_TRIG_LEVEL     2'h0
`define DIC_TRIG_EDGE      2'h1
`define DIC_TRIG_BOTH      2'h2

`endif

//--- design/dic_status_stack.v
// Status stack pushed on interrupt entry, popped on return
`timescale 1ns/1ns
`default_nettype none
module dic_status_stack #(
	parameter WIDTH = 16,
	parameter DEPTH = 16,
	parameter PW    = 5
) (
	input  wire             mclk,
	input  wire             rst,
	input  wire             ce,
	input  wire             push,
	input  wire             pop,
	input  wire [WIDTH-1:0] push_data,
	output reg  [WIDTH-1:0] top_data,
	output reg  [PW-1:0]    level
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	wire            do_push;
	wire            do_pop;

	assign do_push = push && (level < DEPTH[PW-1:0]);
	assign do_pop  = pop && !push && (level != {PW{1'b0}});

	always @(posedge mclk) begin
		if (ce && do_push) begin
			mem[level[PW-2:0]] <= push_data;
		end
	end

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			level    <= {PW{1'b0}};
			top_data <= {WIDTH{1'b0}};
		end else if (ce) begin
			if (do_push) begin
				level    <= level + 1'b1;
				top_data <= push_data;
			end else if (do_pop) begin
				level <= level - 1'b1;
				if (level > {{(PW-1){1'b0}}, 1'b1}) begin
					top_data <= mem[level[PW-2:0] - 2'd2];
				end
			end
		end
	end
endmodule // dic_status_stack
`default_nettype wire

//--- design/dic_controller.v
// Prioritising interrupt controller for the DSP core
`include "dic_defs.vh"
`timescale 1ns/1ns
`default_nettype none
module dic_controller #(
	parameter NP = `DIC_NUM_PERIPH
) (
	input  wire          mclk,
	input  wire          rst,
	input  wire          ce,
	input  wire [3:0]    reg_addr,
	input  wire [15:0]   reg_wdata,
	input  wire          reg_wr,
	input  wire          reg_rd,
	output reg  [15:0]   reg_rdata,
	input  wire [NP-1:0] periph_irq,
	input  wire [1:0]    programmable_flag_pin,
	input  wire          emu_irq,
	input  wire          reset_irq,
	input  wire          pwrdn_irq,
	input  wire          kernel_irq,
	input  wire          global_enable_instr,
	input  wire          global_disable_instr,
	input  wire          no_boot,
	input  wire          pc_push,
	input  wire          pc_pop,
	input  wire          loop_push,
	input  wire          loop_pop,
	input  wire [15:0]   core_status,
	input  wire          rti,
	input  wire          vector_ack,
	output reg           vector_req,
	output reg  [23:0]   vector_addr,
	output reg           emu_req,
	output wire [15:0]   status_top,
	output wire          biased_round
);
	////////////////////////////////////////////////////////////////////////////
	reg  [15:0]   interrupt_control_reg;
	reg  [15:0]   interrupt_mask_reg;
	reg  [15:0]   interrupt_latch_reg;
	reg  [59:0]   prio;
	reg  [3:0]    flag_cfg;
	reg  [1:0]    flag_prev;
	reg  [5:0]    pc_level;
	reg  [3:0]    loop_level;
	reg  [15:0]   active;
	reg  [3:0]    sel_bit;
	reg           sel_valid;
	reg  [15:0]   next_latch;
	reg  [15:0]   pend;
	reg  [15:0]   perm;
	reg  [15:0]   periph_bits;
	reg  [NP-1:0] src;
	reg  [15:0]   next_active;
	wire [4:0]    stat_level;
	wire          stack_evt;
	wire          take;
	wire          ret;
	wire [1:0]    flag_src;
	integer       i;
	integer       j;

	function [3:0] bit_of_level;
		input [3:0] lvl;
		begin
			// Levels beyond 11 alias to bit 15, the lowest priority
			if (lvl >= `DIC_LVL_LOWEST) begin
				bit_of_level = 4'hF;
			end else begin
				bit_of_level = lvl + 4'h4;
			end
		end
	endfunction

	function [3:0] highest;
		input [15:0] v;
		integer k;
		begin
			highest = 4'h0;
			for (k = 15; k >= 0; k = k - 1) begin
				if (v[k]) begin
					highest = k[3:0];
				end
			end
		end
	endfunction

	assign biased_round = interrupt_control_reg[`DIC_CTL_BIAS];
	assign take = vector_req && vector_ack;
	assign ret  = rti && (active != 16'h0000);

	////////////////////////////////////////////////////////////////////////////
	// Flag pin sources, mode per pin
	genvar g;
	generate
		for (g = 0; g < 2; g = g + 1) begin : g_flag
			assign flag_src[g] = (flag_cfg[2*g +: 2] == `DIC_TRIG_EDGE) ?
				(programmable_flag_pin[g] && !flag_prev[g]) :
				(flag_cfg[2*g +: 2] == `DIC_TRIG_BOTH) ?
				(programmable_flag_pin[g] ^ flag_prev[g]) : programmable_flag_pin[g];
		end
	endgenerate

	always @* begin
		src[11:0]  = periph_irq[11:0];
		src[13:12] = flag_src;
		src[14]    = periph_irq[14];
		periph_bits = 16'h0000;
		for (i = 0; i < NP; i = i + 1) begin
			if (src[i]) begin
				periph_bits[bit_of_level(prio[4*i +: 4])] = 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Stack depth tracking
	// stack depths
	dic_status_stack #(
		.WIDTH (16),
		.DEPTH (`DIC_STAT_DEPTH),
		.PW    (5)
	) u_stat (
		.mclk      (mclk),
		.rst       (rst),
		.ce        (ce),
		.push      (take),
		.pop       (ret),
		.push_data (core_status),
		.top_data  (status_top),
		.level     (stat_level)
	);

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			pc_level   <= 6'h00;
			loop_level <= 4'h0;
			flag_prev  <= 2'h0;
		end else if (ce) begin
			flag_prev <= programmable_flag_pin;
			if (pc_push && !pc_pop && pc_level < `DIC_PC_DEPTH) begin
				pc_level <= pc_level + 6'h01;
			end else if (pc_pop && !pc_push && pc_level != 6'h00) begin
				pc_level <= pc_level - 6'h01;
			end
			if (loop_push && !loop_pop && loop_level < `DIC_LOOP_DEPTH) begin
				loop_level <= loop_level + 4'h1;
			end else if (loop_pop && !loop_push && loop_level != 4'h0) begin
				loop_level <= loop_level - 4'h1;
			end
		end
	end

	assign stack_evt = (interrupt_control_reg[`DIC_CTL_PCSTK] &&
		(pc_level < `DIC_PC_LOW || pc_level > `DIC_PC_HIGH)) ||
		(interrupt_control_reg[`DIC_CTL_LPSTK] && loop_level == `DIC_LOOP_DEPTH);

	////////////////////////////////////////////////////////////////////////////
	// Latch, masking and selection
	always @* begin
		next_latch = interrupt_latch_reg;
		if (reg_wr && reg_addr == `DIC_ADDR_LATCH) begin
			next_latch = reg_wdata;
		end
		if (take) begin
			next_latch[sel_bit] = 1'b0;
		end
		next_latch = next_latch | periph_bits;
		next_latch[`DIC_BIT_RESET]  = next_latch[`DIC_BIT_RESET] | reset_irq;
		next_latch[`DIC_BIT_PWRDN]  = next_latch[`DIC_BIT_PWRDN] | pwrdn_irq;
		next_latch[`DIC_BIT_STACK]  = next_latch[`DIC_BIT_STACK] | stack_evt;
		next_latch[`DIC_BIT_KERNEL] = next_latch[`DIC_BIT_KERNEL] | kernel_irq;
	end

	always @* begin
		pend = interrupt_latch_reg & (interrupt_mask_reg | 16'h0003);
		if (!interrupt_control_reg[`DIC_CTL_GIE]) begin
			pend = pend & 16'h0001;
		end
		if (active == 16'h0000) begin
			perm = 16'hFFFF;
		end else if (interrupt_control_reg[`DIC_CTL_NEST]) begin
			perm = 16'h0000;
			for (j = 0; j < 16; j = j + 1) begin
				if (j < highest(active) || (j == 0 && !active[0])) begin
					perm[j] = 1'b1;
				end
			end
		end else begin
			perm = 16'h0001;
		end
		pend = pend & perm;
		sel_valid = pend != 16'h0000;
		sel_bit = highest(pend);
		next_active = active;
		if (take) begin
			next_active[sel_bit] = 1'b1;
		end else if (ret) begin
			next_active[highest(active)] = 1'b0;
		end
	end

	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			interrupt_latch_reg <= 16'h0000;
			active              <= 16'h0000;
			vector_req          <= 1'b0;
			vector_addr         <= 24'h000000;
			emu_req             <= 1'b0;
		end else if (ce) begin
			interrupt_latch_reg <= next_latch;
			active              <= next_active;
			emu_req             <= emu_irq;
			vector_req          <= sel_valid && !take && !emu_irq;
			vector_addr <= (no_boot ? `DIC_VEC_NOBOOT : `DIC_VEC_BASE) +
				{15'h0000, sel_bit, 5'h00};
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register port
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			interrupt_control_reg <= 16'h0000;
			interrupt_mask_reg    <= 16'h0000;
			prio                  <= `DIC_PRIO_RESET;
			flag_cfg              <= 4'h0;
			reg_rdata             <= 16'h0000;
		end else if (ce) begin
			if (global_enable_instr) begin
				interrupt_control_reg[`DIC_CTL_GIE] <= 1'b1;
			end else if (global_disable_instr) begin
				interrupt_control_reg[`DIC_CTL_GIE] <= 1'b0;
			end else if (reg_wr && reg_addr == `DIC_ADDR_CONTROL) begin
				interrupt_control_reg <= reg_wdata & `DIC_CTL_WMASK;
			end
			if (reg_wr) begin
				if (reg_addr == `DIC_ADDR_MASK) begin
					interrupt_mask_reg <= reg_wdata;
				end else if (reg_addr == `DIC_ADDR_PRIO0) begin
					prio[15:0] <= reg_wdata;
				end else if (reg_addr == `DIC_ADDR_PRIO1) begin
					prio[31:16] <= reg_wdata;
				end else if (reg_addr == `DIC_ADDR_PRIO2) begin
					prio[47:32] <= reg_wdata;
				end else if (reg_addr == `DIC_ADDR_PRIO3) begin
					prio[59:48] <= reg_wdata[11:0];
				end else if (reg_addr == `DIC_ADDR_FLAGCFG) begin
					flag_cfg <= reg_wdata[3:0];
				end
			end
			if (!reg_rd) begin
				reg_rdata <= 16'h0000;
			end else if (reg_addr == `DIC_ADDR_CONTROL) begin
				reg_rdata <= interrupt_control_reg;
			end else if (reg_addr == `DIC_ADDR_MASK) begin
				reg_rdata <= interrupt_mask_reg;
			end else if (reg_addr == `DIC_ADDR_LATCH) begin
				reg_rdata <= interrupt_latch_reg;
			end else if (reg_addr == `DIC_ADDR_PRIO0) begin
				reg_rdata <= prio[15:0];
			end else if (reg_addr == `DIC_ADDR_PRIO1) begin
				reg_rdata <= prio[31:16];
			end else if (reg_addr == `DIC_ADDR_PRIO2) begin
				reg_rdata <= prio[47:32];
			end else if (reg_addr == `DIC_ADDR_PRIO3) begin
				reg_rdata <= {4'h0, prio[59:48]};
			end else if (reg_addr == `DIC_ADDR_FLAGCFG) begin
				reg_rdata <= {12'h000, flag_cfg};
			end else if (reg_addr == `DIC_ADDR_STATUS) begin
				reg_rdata <= {1'b0, stat_level, loop_level[3:0], pc_level};
			end else begin
				reg_rdata <= 16'h0000;
			end
		end
	end
endmodule // dic_controller
`default_nettype wire

//--- verif/dic_controller_monitor.sv
// Assertion checker for the DSP interrupt controller
`timescale 1ns/1ns
`default_nettype none
module dic_monitor (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic [3:0]  reg_addr,
	input wire logic [15:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        emu_irq,
	input wire logic        reset_irq,
	input wire logic        global_enable_instr,
	input wire logic        global_disable_instr,
	input wire logic        no_boot,
	input wire logic [15:0] core_status,
	input wire logic        vector_ack,
	input wire logic        vector_req,
	input wire logic [23:0] vector_addr,
	input wire logic        emu_req,
	input wire logic [15:0] status_top,
	input wire logic        biased_round
);
	logic gie;
	default clocking @(posedge mclk); endclocking
	default disable iff (rst);
	// Mirror of the global enable bit
	always @(posedge mclk or posedge rst)
		if (rst)
			gie <= 1'b0;
		else if (global_enable_instr)
			gie <= 1'b1;
		else if (global_disable_instr)
			gie <= 1'b0;
		else if (reg_wr && reg_addr == 4'h0)
			gie <= reg_wdata[5];
	emu_follow_a:
		assert property (emu_irq |=> emu_req) else $error("emu_req missing");
	vec_form_a:
		assert property (vector_req && !no_boot |-> vector_addr[23:9] == 15'h0
			&& vector_addr[4:0] == 5'h0) else $error("bad vector");
	vec_noboot_a:
		assert property (vector_req && no_boot |-> vector_addr[23:16] == 8'h01)
			else $error("vector not relocated");
	ack_drop_a:
		assert property (vector_req && vector_ack |=> !vector_req)
			else $error("vector_req held");
	bias_bit_a:
		assert property (reg_wr && reg_addr == 4'h0 |=> biased_round == $past(reg_wdata[7]))
			else $error("biased_round wrong");
	reset_vec_a:
		assert property ($rose(reset_irq) |-> ##[1:4] (vector_req && vector_addr[8:0] == 9'h0))
			else $error("reset not vectored");
	gie_block_a:
		assert property ($rose(vector_req) |-> $past(gie) || vector_addr[8:0] == 9'h0)
			else $error("vector while disabled");
	status_push_a:
		assert property (vector_req && vector_ack |-> ##[1:2] status_top == core_status)
			else $error("status not pushed");
	cover property (vector_req && vector_ack && no_boot);
	cover property ($rose(reset_irq));
	cover property (emu_req);
endmodule // dic_monitor
bind dic_controller dic_monitor u_mon (.*);
`default_nettype wire

//--- verif/dic_seq_model.sv
// Behavioural program sequencer taking vectors
`timescale 1ns/1ns
`default_nettype none
module dic_seq_model (
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        vector_req,
	input  wire logic [23:0] vector_addr,
	input  wire logic [3:0]  delay,
	output var  logic        vector_ack,
	output var  logic        rti,
	output var  logic [23:0] taken,
	output var  logic [7:0]  n_taken
);
	logic [3:0] wait_cnt;
	logic       ret_d;
	// Takes a vector after delay cycles, returns two later
	always @(posedge mclk or posedge rst) begin
		if (rst) begin
			{vector_ack, rti, ret_d, wait_cnt, n_taken, taken} <= '0;
		end else begin
			{rti, ret_d} <= {ret_d, vector_ack};
			if (vector_ack) begin
				vector_ack <= 1'b0;
				taken <= vector_addr;
				n_taken <= n_taken + 8'h01;
				wait_cnt <= 4'h0;
			end else if (vector_req && wait_cnt == delay)
				vector_ack <= 1'b1;
			else if (vector_req)
				wait_cnt <= wait_cnt + 4'h1;
			else
				wait_cnt <= 4'h0;
		end
	end
endmodule // dic_seq_model
`default_nettype wire

//--- verif/test_dsp_interrupt_controller.sv
// Self-checking testbench for the DSP interrupt controller
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin miscompares++; \
	$display("[ERR] %s exp %h got %h", n, e, a); end end
module test_dsp_interrupt_controller;
	logic        mclk, rst, ce, reg_wr, reg_rd, emu_irq, reset_irq, pwrdn_irq, kernel_irq;
	logic        global_enable_instr, global_disable_instr, no_boot, pc_push, pc_pop;
	logic        loop_push, loop_pop, rti, vector_ack, vector_req, emu_req, biased_round;
	logic [1:0]  programmable_flag_pin;
	logic [3:0]  reg_addr, delay;
	logic [7:0]  n_taken;
	logic [14:0] periph_irq;
	logic [15:0] reg_wdata, reg_rdata, core_status, status_top;
	logic [23:0] vector_addr, taken;
	int          miscompares, cmp_count;
	dic_controller dut (.*);
	dic_seq_model u_seq (.*);
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge mclk);
		reg_wr <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] e);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge mclk);
		reg_rd <= 1'b0;
		#1;
		`CHK("rdata", e, reg_rdata)
		@(posedge mclk);
	endtask
	task automatic vec(input logic [23:0] e);
		logic [7:0] n0;
		n0 = n_taken;
		for (int i = 0; i < 30 && n_taken === n0; i++)
			@(posedge mclk);
		`CHK("vector count", n0 + 8'h01, n_taken)
		`CHK("vector", e, taken)
		repeat (3) @(posedge mclk);
	endtask
	task automatic idle;
		logic [7:0] n0;
		n0 = n_taken;
		repeat (8) @(posedge mclk);
		`CHK("no vector", n0, n_taken)
	endtask
	////////////////////////////////////////////////////////////////
	task t_reset;
		rd(4'h0, 16'h0000);
		rd(4'h1, 16'h0000);
		rd(4'h3, 16'h3210);
		rd(4'h4, 16'h7654);
		rd(4'h5, 16'hBA98);
		rd(4'h6, 16'h0BBB);
		rd(4'hF, 16'h0000);
	endtask
	task t_mask;
		global_enable_instr <= 1'b1;
		@(posedge mclk);
		global_enable_instr <= 1'b0;
		periph_irq <= 15'h0002;
		@(posedge mclk);
		periph_irq <= 15'h0000;
		idle;
		rd(4'h2, 16'h0020);
		wr(4'h1, 16'h0020);
		vec(24'h0000A0);
		rd(4'h2, 16'h0000);
		wr(4'h0, 16'h00A0);
		rd(4'h0, 16'h00A0);
		wr(4'h1, 16'h0008);
		kernel_irq <= 1'b1;
		@(posedge mclk);
		kernel_irq <= 1'b0;
		vec(24'h000060);
	endtask
	task t_prio;
		delay <= 4'h3;
		core_status <= 16'hC3C3;
		wr(4'h1, 16'h8000);
		wr(4'h3, 16'h321B);
		periph_irq <= 15'h0001;
		@(posedge mclk);
		periph_irq <= 15'h0000;
		vec(24'h0001E0);
		wr(4'h7, 16'h0001);
		programmable_flag_pin <= 2'h1;
		vec(24'h0001E0);
		programmable_flag_pin <= 2'h0;
		delay <= 4'h0;
		repeat (4) @(posedge mclk);
		wr(4'h2, 16'h0000);
		rd(4'h2, 16'h0000);
	endtask
	task t_nmi;
		global_disable_instr <= 1'b1;
		@(posedge mclk);
		global_disable_instr <= 1'b0;
		pwrdn_irq <= 1'b1;
		@(posedge mclk);
		pwrdn_irq <= 1'b0;
		idle;
		reset_irq <= 1'b1;
		@(posedge mclk);
		reset_irq <= 1'b0;
		vec(24'h000000);
		global_enable_instr <= 1'b1;
		@(posedge mclk);
		global_enable_instr <= 1'b0;
		vec(24'h000020);
		emu_irq <= 1'b1;
		repeat (2) @(posedge mclk);
		#1;
		`CHK("emu_req", 1'b1, emu_req)
		@(posedge mclk);
		emu_irq <= 1'b0;
	endtask
	task t_latch;
		wr(4'h1, 16'h0040);
		wr(4'h2, 16'h0040);
		vec(24'h0000C0);
		no_boot <= 1'b1;
		wr(4'h2, 16'h0040);
		vec(24'h0100C0);
		no_boot <= 1'b0;
		wr(4'h2, 16'h0010);
		rd(4'h2, 16'h0010);
	endtask
	task t_stack;
		wr(4'h1, 16'h0004);
		wr(4'h0, 16'h0420);
		vec(24'h000040);
		wr(4'h0, 16'h0000);
		pc_push <= 1'b1;
		loop_push <= 1'b1;
		repeat (9) @(posedge mclk);
		loop_push <= 1'b0;
		repeat (21) @(posedge mclk);
		pc_push <= 1'b0;
		rd(4'h8, 16'h021E);
	endtask
	task wrap_up;
		$display("Checks %0d, mismatches %0d", cmp_count, miscompares);
		if (miscompares == 0 && cmp_count > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end
	initial begin
		repeat (20000) @(posedge mclk);
		miscompares++;
		wrap_up;
	end
	initial begin
		{rst, ce, reg_wr, reg_rd, emu_irq, reset_irq, pwrdn_irq, kernel_irq} = 8'hC0;
		{global_enable_instr, global_disable_instr, no_boot, pc_push, pc_pop} = '0;
		{loop_push, loop_pop, programmable_flag_pin, periph_irq} = '0;
		{reg_addr, delay, reg_wdata} = '0;
		core_status = 16'h5A5A;
		repeat (20) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		t_reset;
		t_mask;
		t_prio;
		t_nmi;
		t_latch;
		t_stack;
		wrap_up;
	end
endmodule // test_dsp_interrupt_controller
`default_nettype wire
